// File: rtl/rps_pkg.sv
// Package with offsets, bit positions, reset values and timing for the root port status bank
package rps_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  RPS_OFS_PORT_BASE   = 8'h54;
	localparam logic [31:0] RPS_RESET_VALUE     = 32'h0000_0000;
	localparam int          RPS_DEFAULT_PORTS   = 2;

	// ==========================================================
	// Lower half-word status bits
	localparam int RPS_BIT_CONNECTED    = 0;
	localparam int RPS_BIT_ENABLED      = 1;
	localparam int RPS_BIT_SUSPENDED    = 2;
	localparam int RPS_BIT_OVERCURRENT  = 3;
	localparam int RPS_BIT_RESET_ACTIVE = 4;
	localparam int RPS_BIT_POWER_ON     = 8;
	localparam int RPS_BIT_SLOW_DEVICE  = 9;

	// ==========================================================
	// Upper half-word change bits
	localparam int RPS_BIT_CONNECT_CHG  = 16;
	localparam int RPS_BIT_ENABLE_CHG   = 17;
	localparam int RPS_BIT_SUSPEND_CHG  = 18;
	localparam int RPS_BIT_OVERCUR_CHG  = 19;
	localparam int RPS_BIT_RESET_CHG    = 20;

	// ==========================================================
	// Write command bits (same positions, write meaning)
	localparam int RPS_CMD_CLR_ENABLE   = 0;
	localparam int RPS_CMD_SET_ENABLE   = 1;
	localparam int RPS_CMD_SET_SUSPEND  = 2;
	localparam int RPS_CMD_CLR_SUSPEND  = 3;
	localparam int RPS_CMD_SET_RESET    = 4;
	localparam int RPS_CMD_SET_POWER    = 8;
	localparam int RPS_CMD_CLR_POWER    = 9;

	// ==========================================================
	// Timing
	localparam int RPS_CLK_MHZ          = 100;
	localparam int RPS_RESET_MS         = 10;
	localparam int RPS_RESUME_MS        = 20;
	localparam int RPS_RESYNC_MS        = 3;
	localparam int RPS_EOP_US           = 2;
	localparam int RPS_RESET_CYCLES     = RPS_RESET_MS * 1000 * RPS_CLK_MHZ;
	localparam int RPS_RESUME_CYCLES    = RPS_RESUME_MS * 1000 * RPS_CLK_MHZ;
	localparam int RPS_RESYNC_CYCLES    = RPS_RESYNC_MS * 1000 * RPS_CLK_MHZ;
	localparam int RPS_EOP_CYCLES       = RPS_EOP_US * RPS_CLK_MHZ;
	localparam int RPS_CNT_W            = 24;

endpackage : rps_pkg

// File: rtl/rps_port.sv
// One root hub port status register with its reset and resume sequencing
`timescale 1ns/1ps
`default_nettype none

module rps_port
	import rps_pkg::*;
#(
	parameter int RESET_CYC  = RPS_RESET_CYCLES,
	parameter int RESUME_CYC = RPS_RESUME_CYCLES,
	parameter int EOP_CYC    = RPS_EOP_CYCLES,
	parameter int RESYNC_CYC = RPS_RESYNC_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// Mode
	input  wire logic        per_port_oc_i,
	// Write command, already deferred past any transaction
	input  wire logic        wr_i,
	input  wire logic [31:0] wdata_i,
	// Port line conditions, already synchronised
	input  wire logic        attach_i,
	input  wire logic        slow_i,
	input  wire logic        overcur_i,
	input  wire logic        hw_disable_i,
	input  wire logic        remote_resume_i,
	// Register value and port drive requests
	output logic      [31:0] status_o,
	output logic             reset_drive_o,
	output logic             resume_drive_o
);

	// ==========================================================
	// Sequencer
	typedef enum logic [4:0] {
		RPS_IDLE   = 5'b00001,
		RPS_RESET  = 5'b00010,
		RPS_RESUME = 5'b00100,
		RPS_EOP    = 5'b01000,
		RPS_RESYNC = 5'b10000
	} rps_seq_t;

	localparam logic [RPS_CNT_W-1:0] RST_N = RPS_CNT_W'(RESET_CYC - 1);
	localparam logic [RPS_CNT_W-1:0] RSM_N = RPS_CNT_W'(RESUME_CYC - 1);
	localparam logic [RPS_CNT_W-1:0] EOP_N = RPS_CNT_W'(EOP_CYC - 1);
	localparam logic [RPS_CNT_W-1:0] SYN_N = RPS_CNT_W'(RESYNC_CYC - 1);

	rps_seq_t               seq_r, seq_nxt;
	logic [RPS_CNT_W-1:0]   cnt_r, cnt_nxt;
	logic [31:0]            st_r, st_nxt;
	logic                   att_d_r;

	always_comb begin
		logic cmd_ok;
		logic rst_done;
		logic rsm_done;
		cmd_ok   = 1'b0;
		rst_done = 1'b0;
		rsm_done = 1'b0;
		seq_nxt  = seq_r;
		cnt_nxt  = cnt_r;
		st_nxt   = st_r;
		cmd_ok   = wr_i && st_r[RPS_BIT_CONNECTED];
		// Current conditions
		st_nxt[RPS_BIT_CONNECTED]   = attach_i;
		st_nxt[RPS_BIT_SLOW_DEVICE] = attach_i & slow_i;           // [R15]
		if (st_r[RPS_BIT_OVERCURRENT] != overcur_i) begin
			st_nxt[RPS_BIT_OVERCURRENT] = overcur_i;
		end
		case (seq_r)
			RPS_IDLE: begin
				if (cmd_ok && wdata_i[RPS_CMD_SET_RESET]) begin
					seq_nxt = RPS_RESET;
					cnt_nxt = RST_N;
				end else if (st_r[RPS_BIT_SUSPENDED] &&
				             ((wr_i && wdata_i[RPS_CMD_CLR_SUSPEND]) || remote_resume_i)) begin
					seq_nxt = RPS_RESUME;
					cnt_nxt = RSM_N;
				end
			end
			RPS_RESET: begin
				if (cnt_r == '0) begin
					seq_nxt  = RPS_IDLE;
					rst_done = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			RPS_RESUME: begin
				if (cnt_r == '0) begin
					seq_nxt = RPS_EOP;
					cnt_nxt = EOP_N;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			RPS_EOP: begin
				if (cnt_r == '0) begin
					seq_nxt = RPS_RESYNC;
					cnt_nxt = SYN_N;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			RPS_RESYNC: begin
				if (cnt_r == '0) begin
					seq_nxt  = RPS_IDLE;
					rsm_done = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				seq_nxt = RPS_IDLE;
				cnt_nxt = '0;
			end
		endcase
		if (!attach_i && seq_r != RPS_IDLE) begin
			seq_nxt = RPS_IDLE;
			cnt_nxt = '0;
		end
		st_nxt[RPS_BIT_RESET_ACTIVE] = (seq_nxt == RPS_RESET);

		// Software writes to status (no enable change flag from these) [R12]
		if (cmd_ok && wdata_i[RPS_CMD_SET_ENABLE]) st_nxt[RPS_BIT_ENABLED] = 1'b1;
		if (wr_i && wdata_i[RPS_CMD_CLR_ENABLE]) st_nxt[RPS_BIT_ENABLED] = 1'b0;
		if (cmd_ok && wdata_i[RPS_CMD_SET_SUSPEND] && st_r[RPS_BIT_ENABLED]) begin
			st_nxt[RPS_BIT_SUSPENDED] = 1'b1;
		end
		if (wr_i && wdata_i[RPS_CMD_SET_POWER]) st_nxt[RPS_BIT_POWER_ON] = 1'b1;
		if (wr_i && wdata_i[RPS_CMD_CLR_POWER]) st_nxt[RPS_BIT_POWER_ON] = 1'b0;  // [R15]
		if (rst_done) begin
			st_nxt[RPS_BIT_ENABLED]   = 1'b1;
			st_nxt[RPS_BIT_SUSPENDED] = 1'b0;
		end
		if (rsm_done) st_nxt[RPS_BIT_SUSPENDED] = 1'b0;

		// Change flags: write one clears, hardware set wins [R6]
		st_nxt[20:16] = st_r[20:16] & ~({5{wr_i}} & wdata_i[20:16]);
		if (att_d_r != attach_i) st_nxt[RPS_BIT_CONNECT_CHG] = 1'b1;            // [R13]
		if (wr_i && !st_r[RPS_BIT_CONNECTED] &&
		    (wdata_i[RPS_CMD_SET_RESET] | wdata_i[RPS_CMD_SET_ENABLE] |
		     wdata_i[RPS_CMD_SET_SUSPEND])) begin
			st_nxt[RPS_BIT_CONNECT_CHG] = 1'b1;                                   // [R14]
		end
		if ((hw_disable_i || !attach_i || overcur_i) && st_r[RPS_BIT_ENABLED]) begin
			st_nxt[RPS_BIT_ENABLED]    = 1'b0;
			st_nxt[RPS_BIT_ENABLE_CHG] = 1'b1;                                    // [R11]
		end
		if (overcur_i) st_nxt[RPS_BIT_POWER_ON] = 1'b0;                           // [R16]
		if (per_port_oc_i && st_r[RPS_BIT_OVERCURRENT] != overcur_i) begin
			st_nxt[RPS_BIT_OVERCUR_CHG] = 1'b1;                                   // [R7] [R8]
		end
		if (rsm_done) st_nxt[RPS_BIT_SUSPEND_CHG] = 1'b1;                         // [R9]
		if (rst_done) begin
			st_nxt[RPS_BIT_RESET_CHG]   = 1'b1;                                   // [R5]
			st_nxt[RPS_BIT_SUSPEND_CHG] = 1'b0;                                   // [R10]
		end
		st_nxt[31:21] = '0;
		st_nxt[15:10] = '0;
		st_nxt[7:5]   = '0;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_r   <= RPS_IDLE;
			cnt_r   <= '0;
			st_r    <= RPS_RESET_VALUE;                                           // [R17]
			att_d_r <= 1'b0;
		end else begin
			seq_r   <= seq_nxt;
			cnt_r   <= cnt_nxt;
			st_r    <= st_nxt;
			att_d_r <= attach_i;
		end
	end

	assign status_o       = st_r;                                                 // [R1]
	assign reset_drive_o  = (seq_r == RPS_RESET);
	assign resume_drive_o = (seq_r == RPS_RESUME) || (seq_r == RPS_EOP);

endmodule : rps_port

`default_nettype wire

// File: rtl/rps_bank.sv
// Root hub per-port status and change register bank
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - Each port has a register: low half status, high half change flags.
// R2 - Number of port registers equals the advertised downstream port count.
// R3 - A write arriving during a port transaction is held until it finishes.
// R4 - Software writes zero to unused bits 31 to 21.
// R5 - Reset-done change flag, bit 20, sets when 10 ms port reset ends.
// R6 - Change flags 20 to 16 clear on writing one; zero leaves them.
// R7 - Overcurrent change flag bit 19 only meaningful with per-port reporting.
// R8 - Overcurrent change sets whenever the port overcurrent indicator changes; the port sets it only when per_port_oc_i is high.
// R9 - Suspend change, bit 18, sets after resume pulse, EOP and resync delay.
// R10 - Suspend change clears whenever reset-done change sets.
// R11 - Enable change, bit 17, sets when hardware clears port enabled.
// R12 - Software changes to port enabled never set enable change.
// R13 - Connect change, bit 16, sets on attach or detach; write one clears.
// R14 - Set-reset, set-enable or set-suspend while disconnected sets connect change.
// R15 - Bit 9 reads slow device attached; writing one clears port power.
// R16 - Port power bit 8 clears when overcurrent is detected.
// R17 - Low byte: connected, enabled, suspended, overcurrent, reset active; resets zero.
module rps_bank
	import rps_pkg::*;
#(
	parameter int NPORTS     = RPS_DEFAULT_PORTS,
	parameter int RESET_CYC  = RPS_RESET_CYCLES,
	parameter int RESUME_CYC = RPS_RESUME_CYCLES,
	parameter int EOP_CYC    = RPS_EOP_CYCLES,
	parameter int RESYNC_CYC = RPS_RESYNC_CYCLES
) (
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	// Operational register access
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	output logic      [31:0]       reg_rdata_o,
	// Mode
	input  wire logic              per_port_oc_i,
	// Port conditions from the line side
	input  wire logic [NPORTS-1:0] attach_i,
	input  wire logic [NPORTS-1:0] slow_i,
	input  wire logic [NPORTS-1:0] overcur_i,
	input  wire logic [NPORTS-1:0] hw_disable_i,
	input  wire logic [NPORTS-1:0] remote_resume_i,
	input  wire logic [NPORTS-1:0] busy_i,
	// Port drive requests and pending-write flags
	output logic      [NPORTS-1:0] reset_drive_o,
	output logic      [NPORTS-1:0] resume_drive_o,
	output logic      [NPORTS-1:0] write_pending_o
);

	// ==========================================================
	// Pin synchronisers
	localparam int SW = 5 * NPORTS;
	logic [SW-1:0] sy1_r, sy2_r;
	logic [NPORTS-1:0] att_s, slw_s, oc_s, dis_s, rsm_s;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sy1_r <= '0;
			sy2_r <= '0;
		end else begin
			sy1_r <= {remote_resume_i, hw_disable_i, overcur_i, slow_i, attach_i};
			sy2_r <= sy1_r;
		end
	end
	assign {rsm_s, dis_s, oc_s, slw_s, att_s} = sy2_r;

	// ==========================================================
	// Per-port registers
	logic [31:0] status_w [NPORTS];
	logic [31:0] rdata_nxt, rdata_r;

	genvar g;
	generate
		for (g = 0; g < NPORTS; g++) begin : g_port                         // [R2]
			localparam logic [7:0] OFS = RPS_OFS_PORT_BASE + 8'(4 * g);
			logic        pend_r, pend_nxt;
			logic [31:0] pdat_r, pdat_nxt;
			logic        hit;
			logic        apply;
			logic [31:0] adat;

			assign hit = reg_wr_i && (reg_addr_i == OFS);

			// Hold a write while the port has a transaction in flight
			always_comb begin
				pend_nxt = pend_r;
				pdat_nxt = pdat_r;
				apply    = 1'b0;
				adat     = pdat_r;
				if (hit && busy_i[g]) begin                                   // [R3]
					pend_nxt = 1'b1;
					pdat_nxt = reg_wdata_i & 32'h001F_FFFF;                   // [R4]
				end else if (hit) begin
					apply    = 1'b1;
					adat     = reg_wdata_i & 32'h001F_FFFF;
					pend_nxt = 1'b0;
				end else if (pend_r && !busy_i[g]) begin                      // [R3]
					apply    = 1'b1;
					pend_nxt = 1'b0;
				end
			end

			always_ff @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					pend_r <= 1'b0;
					pdat_r <= '0;
				end else begin
					pend_r <= pend_nxt;
					pdat_r <= pdat_nxt;
				end
			end

			assign write_pending_o[g] = pend_r;

			rps_port #(
				.RESET_CYC  (RESET_CYC),
				.RESUME_CYC (RESUME_CYC),
				.EOP_CYC    (EOP_CYC),
				.RESYNC_CYC (RESYNC_CYC)
			) u_port (
				.clk_sys_i       (clk_sys_i),
				.nrst_i          (nrst_i),
				.per_port_oc_i   (per_port_oc_i),
				.wr_i            (apply),
				.wdata_i         (adat),
				.attach_i        (att_s[g]),
				.slow_i          (slw_s[g]),
				.overcur_i       (oc_s[g]),
				.hw_disable_i    (dis_s[g]),
				.remote_resume_i (rsm_s[g]),
				.status_o        (status_w[g]),
				.reset_drive_o   (reset_drive_o[g]),
				.resume_drive_o  (resume_drive_o[g])
			);
		end
	endgenerate

	// ==========================================================
	// Read data, registered; unmapped offsets read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_i) begin
			rdata_nxt = '0;
			for (int i = 0; i < NPORTS; i++) begin
				if (reg_addr_i == RPS_OFS_PORT_BASE + 8'(4 * i)) begin
					rdata_nxt = status_w[i];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;

endmodule : rps_bank

`default_nettype wire

// File: test/rps_line_model.sv
// Model of the downstream port lines seen by the root port status bank
`timescale 1ns/1ps
`default_nettype none
module rps_line_model #(
	parameter int NPORTS = 2
) (
	// Port drive from the bank
	input  wire logic [NPORTS-1:0] reset_drive_i,
	// Line conditions
	output logic      [NPORTS-1:0] attach_o,
	output logic      [NPORTS-1:0] slow_o,
	output logic      [NPORTS-1:0] overcur_o,
	output logic      [NPORTS-1:0] hw_disable_o,
	output logic      [NPORTS-1:0] resume_o,
	output logic      [NPORTS-1:0] busy_o
);
	// Line levels, changed by the bench on the falling edge
	logic [NPORTS-1:0] att_r, slw_r, ovc_r, dis_r, rsm_r, busy_r;
	initial begin
		att_r = '0;
		slw_r = '0;
		ovc_r = '0;
		dis_r = '0;
		rsm_r = '0;
		busy_r = '0;
	end
	assign attach_o     = att_r;
	assign slow_o       = slw_r;
	assign overcur_o    = ovc_r;
	assign hw_disable_o = dis_r;
	assign resume_o     = rsm_r;
	// A port under reset signalling carries no transaction
	assign busy_o = busy_r & ~reset_drive_i;
endmodule : rps_line_model
`default_nettype wire

// File: test/rps_bank_chk.sv
// Assertion checker for the root port status bank
`timescale 1ns/1ps
`default_nettype none
module rps_bank_chk #(
	parameter int NPORTS = 2
) (
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [31:0]       reg_rdata_o,
	input  wire logic [NPORTS-1:0] busy_i,
	input  wire logic [NPORTS-1:0] reset_drive_o,
	input  wire logic [NPORTS-1:0] resume_drive_o,
	input  wire logic [NPORTS-1:0] write_pending_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	property p_unmapped;
		reg_rd_i && (reg_addr_i < 8'h54 || reg_addr_i >= 8'h54 + 4 * NPORTS)
			|=> reg_rdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_pend_set;
		reg_wr_i && reg_addr_i == 8'h54 && busy_i[0] |=> write_pending_o[0];
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("busy write not held");
	property p_pend_hold;
		write_pending_o[0] && busy_i[0] |=> write_pending_o[0];
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("held write dropped");
	property p_pend_apply;
		write_pending_o[0] && !busy_i[0] |=> !write_pending_o[0];
	endproperty
	a_pend_apply: assert property (p_pend_apply) else $error("held write not applied");
	property p_rst_len;
		$rose(reset_drive_o[0]) |-> reset_drive_o[0] [*8];
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("port reset too short");
	property p_res_len;
		$rose(resume_drive_o[0]) |-> resume_drive_o[0] [*8];
	endproperty
	a_res_len: assert property (p_res_len) else $error("resume pulse too short");
	property p_stand;
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_stand: assert property (p_stand) else $error("read data moved");
	property p_resv;
		reg_rd_i |=> reg_rdata_o[31:21] == 11'h0 && reg_rdata_o[15:10] == 6'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_slow;
		reg_rd_i |=> !(reg_rdata_o[9] && !reg_rdata_o[0]);
	endproperty
	a_slow: assert property (p_slow) else $error("speed shown unconnected");
	c_pend: cover property (write_pending_o[0] ##1 !write_pending_o[0]);
	c_rst: cover property ($fell(reset_drive_o[0]));
	c_res: cover property ($fell(resume_drive_o[0]));
endmodule : rps_bank_chk
bind rps_bank rps_bank_chk #(.NPORTS(NPORTS)) chk_u (.clk_sys_i, .nrst_i, .reg_wr_i,
	.reg_rd_i, .reg_addr_i, .reg_rdata_o, .busy_i, .reset_drive_o, .resume_drive_o,
	.write_pending_o);
`default_nettype wire

// File: test/rps_bank_tb_top.sv
// Self-checking testbench for the root port status bank
`timescale 1ns/1ps
`default_nettype none
module rps_bank_tb_top;
	import rps_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} rps_row_t;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, oc_mode = 1'b1;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic [1:0] att, slw, ovc, hwd, rrs, bsy, rdrv, resd, pend;
	int failures = 0, tests_run = 0;
	rps_row_t rows[7] = '{'{8'h54, 32'h0, 32'h0001_0001}, '{8'h54, 32'h0001_0000, 32'h1},
		'{8'h58, 32'h100, 32'h0001_0301}, '{8'h58, 32'h200, 32'h0001_0201},
		'{8'h54, 32'h2, 32'h3}, '{8'h54, 32'h1, 32'h1}, '{8'h5C, 32'hFFFF_FFFF, 32'h0}};
	always #5 clk_sys_i = ~clk_sys_i;
	rps_line_model #(.NPORTS(2)) line_u (.reset_drive_i(rdrv), .attach_o(att),
		.slow_o(slw), .overcur_o(ovc), .hw_disable_o(hwd), .resume_o(rrs), .busy_o(bsy));
	rps_bank #(.NPORTS(2), .RESET_CYC(20), .RESUME_CYC(30), .EOP_CYC(4), .RESYNC_CYC(10))
		dut_u (.clk_sys_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .per_port_oc_i(oc_mode), .attach_i(att), .slow_i(slw), .overcur_i(ovc),
		.hw_disable_i(hwd), .remote_resume_i(rrs), .busy_i(bsy), .reset_drive_o(rdrv),
		.resume_drive_o(resd), .write_pending_o(pend));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d & 32'h001F_FFFF;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_sys_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		chk(reg_rdata_o, e);
	endtask : rd
	task automatic settle(input int n);
		int k;
		k = 0;
		while ((rdrv !== 2'b00 || resd !== 2'b00) && k < 300) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k >= 300) begin
			failures++;
			$display("ERROR %0t: wait limit reached", $time);
			stop_test();
		end
		repeat (n) @(negedge clk_sys_i);
	endtask : settle
	initial begin
		repeat (3) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		rd(8'h54, 32'h0);
		rd(8'h58, 32'h0);
		$display("reset values done");
		line_u.att_r = 2'b11;
		line_u.slw_r = 2'b10;
		settle(4);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		$display("table done");
		wr(8'h54, 32'h2);
		wr(8'h54, 32'h4);
		rd(8'h54, 32'h7);
		wr(8'h54, 32'h8);
		settle(14);
		rd(8'h54, 32'h0004_0003);
		wr(8'h54, 32'h10);
		settle(3);
		rd(8'h54, 32'h0010_0003);
		wr(8'h54, 32'h0010_0000);
		rd(8'h54, 32'h3);
		$display("reset and resume done");
		line_u.dis_r[0] = 1'b1;
		settle(4);
		line_u.dis_r[0] = 1'b0;
		settle(4);
		rd(8'h54, 32'h0002_0001);
		wr(8'h54, 32'h0002_0000);
		wr(8'h54, 32'h100);
		line_u.ovc_r[0] = 1'b1;
		settle(4);
		rd(8'h54, 32'h0008_0009);
		wr(8'h54, 32'h0008_0000);
		line_u.ovc_r[0] = 1'b0;
		settle(4);
		rd(8'h54, 32'h0008_0001);
		wr(8'h54, 32'h0008_0000);
		$display("disable and overcurrent done");
		line_u.att_r[1] = 1'b0;
		settle(4);
		wr(8'h58, 32'h0001_0000);
		wr(8'h58, 32'h10);
		rd(8'h58, 32'h0001_0000);
		$display("disconnected command done");
		line_u.busy_r = 2'b01;
		wr(8'h54, 32'h100);
		chk(32'(pend), 32'h1);
		rd(8'h54, 32'h1);
		line_u.busy_r = 2'b00;
		rd(8'h54, 32'h101);
		$display("deferred write done");
		wr(8'h54, 32'h2);
		wr(8'h54, 32'h4);
		line_u.rsm_r[0] = 1'b1;
		settle(4);
		settle(14);
		line_u.rsm_r[0] = 1'b0;
		rd(8'h54, 32'h0004_0103);
		wr(8'h54, 32'h0004_0000);
		$display("remote resume done");
		oc_mode = 1'b0;
		line_u.ovc_r[0] = 1'b1;
		settle(4);
		rd(8'h54, 32'h0002_0009);
		line_u.ovc_r[0] = 1'b0;
		settle(4);
		rd(8'h54, 32'h0002_0001);
		oc_mode = 1'b1;
		$display("global overcurrent mode done");
		@(negedge clk_sys_i);
		nrst_i = 1'b0;
		@(negedge clk_sys_i);
		nrst_i = 1'b1;
		rd(8'h54, 32'h0);
		chk(32'(pend), 32'h0);
		$display("mid-run reset done");
		stop_test();
	end
endmodule : rps_bank_tb_top
`default_nettype wire
